// file: hdl/rcr_defs.svh
`ifndef RCR_DEFS_SVH
`define RCR_DEFS_SVH

// ----------------------------------------------------------------
// Restart addresses
// ----------------------------------------------------------------
`define RCR_RESET_VECTOR 13'h0000
`define RCR_IRQ_VECTOR   13'h0004
`define RCR_PC_W         13

// ----------------------------------------------------------------
// Status byte field positions (low five bits used)
// ----------------------------------------------------------------
`define RCR_ST_TO 4
`define RCR_ST_PD 3

// ----------------------------------------------------------------
// Power control byte field positions
// ----------------------------------------------------------------
`define RCR_PC_OVF 7
`define RCR_PC_UNF 6
`define RCR_PC_WDT 4
`define RCR_PC_PIN 3
`define RCR_PC_RI  2
`define RCR_PC_POR 1
`define RCR_PC_BOR 0

// ----------------------------------------------------------------
// Reset values (power-on)
// ----------------------------------------------------------------
`define RCR_STATUS_RST 8'h18
`define RCR_POWER_CONTROL_REG_RST   8'h1C

`endif

// file: hdl/rcr_pkg.sv
package rcr_pkg;

  typedef enum logic [3:0] {
    RCR_EV_NONE     = 4'h0,
    RCR_EV_POR      = 4'h1,
    RCR_EV_BOR      = 4'h2,
    RCR_EV_WDT_RST  = 4'h3,
    RCR_EV_WDT_WAKE = 4'h4,
    RCR_EV_IRQ_WAKE = 4'h5,
    RCR_EV_PIN_RUN  = 4'h6,
    RCR_EV_PIN_SLP  = 4'h7,
    RCR_EV_INSTR    = 4'h8,
    RCR_EV_OVF      = 4'h9,
    RCR_EV_UNF      = 4'hA
  } rcr_event_type;

  typedef enum logic [1:0] {
    RCR_ST_RUN   = 2'b00,
    RCR_ST_SLEEP = 2'b01,
    RCR_ST_VEC   = 2'b11
  } rcr_state_type;

endpackage

// file: hdl/rcr_event_if.sv
`timescale 1ns/1ns
interface rcr_event_if;
  import rcr_pkg::*;
  rcr_event_type ev;
  modport arb  (output ev);
  modport core (input  ev);
endinterface

// file: hdl/rcr_event_arb.sv
`timescale 1ns/1ns
module rcr_event_arb
  import rcr_pkg::*;
(
  input  wire logic por_i,
  input  wire logic bor_i,
  input  wire logic wdt_timeout_i,
  input  wire logic ext_pin_i,
  input  wire logic instr_reset_i,
  input  wire logic stack_ovf_i,
  input  wire logic stack_unf_i,
  input  wire logic stack_fault_reset_en_i,
  input  wire logic irq_wake_i,
  input  wire logic asleep_i,
  rcr_event_if.arb  evt
);
  // ----------------------------------------------------------------
  // Priority pick of one event per cycle
  // ----------------------------------------------------------------
  always_comb begin
    if (por_i)
      evt.ev = RCR_EV_POR;
    else if (bor_i)
      evt.ev = RCR_EV_BOR;
    else if (ext_pin_i)
      evt.ev = asleep_i ? RCR_EV_PIN_SLP : RCR_EV_PIN_RUN;
    else if (wdt_timeout_i)
      evt.ev = asleep_i ? RCR_EV_WDT_WAKE : RCR_EV_WDT_RST;
    else if (stack_ovf_i && stack_fault_reset_en_i)
      evt.ev = RCR_EV_OVF;
    else if (stack_unf_i && stack_fault_reset_en_i)
      evt.ev = RCR_EV_UNF;
    else if (instr_reset_i && !asleep_i)
      evt.ev = RCR_EV_INSTR;
    else if (irq_wake_i && asleep_i)
      evt.ev = RCR_EV_IRQ_WAKE;
    else
      evt.ev = RCR_EV_NONE;
  end
endmodule

// file: hdl/rcr_reset_cause_recorder.sv
`timescale 1ns/1ns
`include "rcr_defs.svh"

// What this block does
// - Every reset event updates flags in the status byte, the power control byte or both.
// - Power-on: restart 0000h, clear stack/power-on/brown-out flags, set others.
// - Power-on always sets both time-out and power-down flags.
// - Brown-out: restart 0000h, clear brown-out/stack flags, keep WDT, POR.
// - Watchdog reset in run: restart 0000h, clear watchdog and time-out.
// - Watchdog wake: clear time-out and power-down, continue at PC+1.
// - Interrupt wake: set time-out, clear power-down, continue at PC+1.
// - Interrupt wake with enable set: after next instruction vector 0004h.
// - Pin reset in run: restart 0000h, clear pin flag only.
// - Pin reset asleep: clear pin flag, set time-out, clear power-down.
// - Reset instruction: restart 0000h, clear instruction flag only.
// - Stack overflow with enable: reset 0000h, set overflow flag.
// - Stack underflow with enable: reset 0000h, set underflow flag.
// - Undefined flags keep their value; unimplemented bits read zero.
module rcr_reset_cause_recorder
  import rcr_pkg::*;
#(
  parameter int PC_W = `RCR_PC_W
)(
  input  wire logic            clock_i,
  input  wire logic            reset_n_i,
  input  wire logic            clk_en_i,
  input  wire logic            por_i,
  input  wire logic            bor_i,
  input  wire logic            wdt_timeout_i,
  input  wire logic            ext_pin_i,
  input  wire logic            instr_reset_i,
  input  wire logic            stack_ovf_i,
  input  wire logic            stack_unf_i,
  input  wire logic            stack_fault_reset_en_i,
  input  wire logic            sleep_req_i,
  input  wire logic            irq_wake_i,
  input  wire logic            global_irq_enable_i,
  input  wire logic            instr_done_i,
  input  wire logic [PC_W-1:0] pc_i,
  input  wire logic            sw_wr_status_i,
  input  wire logic [7:0]      sw_status_i,
  input  wire logic            sw_wr_power_control_reg_i,
  input  wire logic [7:0]      sw_power_control_reg_i,
  output logic [7:0]           status_o,
  output logic [7:0]           power_control_reg_o,
  output logic                 pc_load_o,
  output logic [PC_W-1:0]      pc_target_o,
  output logic                 push_return_o,
  output logic                 asleep_o,
  output rcr_pkg::rcr_event_type last_event_o
);
  import rcr_pkg::*;

  // ----------------------------------------------------------------
  // Event selection
  // ----------------------------------------------------------------
  rcr_event_if evt ();

  rcr_event_arb u_arb (
    .por_i                  (por_i),
    .bor_i                  (bor_i),
    .wdt_timeout_i          (wdt_timeout_i),
    .ext_pin_i              (ext_pin_i),
    .instr_reset_i          (instr_reset_i),
    .stack_ovf_i            (stack_ovf_i),
    .stack_unf_i            (stack_unf_i),
    .stack_fault_reset_en_i (stack_fault_reset_en_i),
    .irq_wake_i             (irq_wake_i),
    .asleep_i               (asleep_o),
    .evt                    (evt)
  );

  function automatic logic is_restart(input rcr_event_type e);
    is_restart = (e != RCR_EV_NONE) && (e != RCR_EV_WDT_WAKE) &&
                 (e != RCR_EV_IRQ_WAKE);
  endfunction

  // ----------------------------------------------------------------
  // Flag registers
  // ----------------------------------------------------------------
  logic [7:0]      status_ff, nxt_status;
  logic [7:0]      power_control_reg_ff,   nxt_power_control_reg;
  rcr_event_type   last_ff,   nxt_last;

  always_comb begin
    nxt_status = status_ff;
    nxt_power_control_reg   = power_control_reg_ff;
    nxt_last   = last_ff;
    if (sw_wr_status_i)
      nxt_status = {3'h0, sw_status_i[4:3], status_ff[2:0]};
    if (sw_wr_power_control_reg_i)
      nxt_power_control_reg = {sw_power_control_reg_i[7:6], 1'b0, sw_power_control_reg_i[4:0]};
    if (evt.ev != RCR_EV_NONE)
      nxt_last = evt.ev;
    case (evt.ev)
      RCR_EV_POR: begin
        nxt_status[`RCR_ST_TO] = 1'b1;
        nxt_status[`RCR_ST_PD] = 1'b1;
        nxt_power_control_reg = `RCR_POWER_CONTROL_REG_RST;
      end
      RCR_EV_BOR: begin
        nxt_status[`RCR_ST_TO] = 1'b1;
        nxt_status[`RCR_ST_PD] = 1'b1;
        nxt_power_control_reg[`RCR_PC_OVF]  = 1'b0;
        nxt_power_control_reg[`RCR_PC_UNF]  = 1'b0;
        nxt_power_control_reg[`RCR_PC_PIN]  = 1'b1;
        nxt_power_control_reg[`RCR_PC_RI]   = 1'b1;
        nxt_power_control_reg[`RCR_PC_BOR]  = 1'b0;
      end
      RCR_EV_WDT_RST: begin
        nxt_status[`RCR_ST_TO] = 1'b0;
        nxt_power_control_reg[`RCR_PC_WDT]  = 1'b0;
      end
      RCR_EV_WDT_WAKE: begin
        nxt_status[`RCR_ST_TO] = 1'b0;
        nxt_status[`RCR_ST_PD] = 1'b0;
      end
      RCR_EV_IRQ_WAKE: begin
        nxt_status[`RCR_ST_TO] = 1'b1;
        nxt_status[`RCR_ST_PD] = 1'b0;
      end
      RCR_EV_PIN_RUN:
        nxt_power_control_reg[`RCR_PC_PIN] = 1'b0;
      RCR_EV_PIN_SLP: begin
        nxt_power_control_reg[`RCR_PC_PIN]  = 1'b0;
        nxt_status[`RCR_ST_TO] = 1'b1;
        nxt_status[`RCR_ST_PD] = 1'b0;
      end
      RCR_EV_INSTR:
        nxt_power_control_reg[`RCR_PC_RI] = 1'b0;
      RCR_EV_OVF:
        nxt_power_control_reg[`RCR_PC_OVF] = 1'b1;
      RCR_EV_UNF:
        nxt_power_control_reg[`RCR_PC_UNF] = 1'b1;
      default: ;
    endcase
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_ff <= `RCR_STATUS_RST;
      power_control_reg_ff   <= `RCR_POWER_CONTROL_REG_RST;
      last_ff   <= RCR_EV_NONE;
    end else if (clk_en_i) begin
      status_ff <= nxt_status;
      power_control_reg_ff   <= nxt_power_control_reg;
      last_ff   <= nxt_last;
    end
  end

  // ----------------------------------------------------------------
  // Sleep and program counter sequencing
  // ----------------------------------------------------------------
  rcr_state_type   state_ff, nxt_state;
  logic            load_ff,  nxt_load;
  logic            push_ff,  nxt_push;
  logic [PC_W-1:0] tgt_ff,   nxt_tgt;
  logic            asleep_ff, nxt_asleep;

  assign nxt_asleep = (nxt_state == RCR_ST_SLEEP);

  always_comb begin
    nxt_state = state_ff;
    nxt_load  = 1'b0;
    nxt_push  = 1'b0;
    nxt_tgt   = tgt_ff;
    if (is_restart(evt.ev)) begin
      nxt_state = RCR_ST_RUN;
      nxt_load  = 1'b1;
      nxt_tgt   = `RCR_RESET_VECTOR;
    end else begin
      case (state_ff)
        RCR_ST_RUN:
          if (sleep_req_i)
            nxt_state = RCR_ST_SLEEP;
        RCR_ST_SLEEP:
          if (evt.ev == RCR_EV_WDT_WAKE) begin
            nxt_state = RCR_ST_RUN;
            nxt_load  = 1'b1;
            nxt_tgt   = PC_W'(pc_i + 1'b1);
          end else if (evt.ev == RCR_EV_IRQ_WAKE) begin
            nxt_state = global_irq_enable_i ? RCR_ST_VEC : RCR_ST_RUN;
            nxt_load  = 1'b1;
            nxt_tgt   = PC_W'(pc_i + 1'b1);
          end
        RCR_ST_VEC:
          if (instr_done_i) begin
            nxt_state = RCR_ST_RUN;
            nxt_load  = 1'b1;
            nxt_push  = 1'b1;
            nxt_tgt   = `RCR_IRQ_VECTOR;
          end
        default:
          nxt_state = RCR_ST_RUN;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_ff <= RCR_ST_RUN;
      load_ff  <= 1'b0;
      push_ff  <= 1'b0;
      tgt_ff   <= `RCR_RESET_VECTOR;
      asleep_ff <= 1'b0;
    end else if (clk_en_i) begin
      state_ff <= nxt_state;
      asleep_ff <= nxt_asleep;
      load_ff  <= nxt_load;
      push_ff  <= nxt_push;
      tgt_ff   <= nxt_tgt;
    end
  end

  assign status_o            = status_ff;
  assign power_control_reg_o = power_control_reg_ff;
  assign pc_load_o           = load_ff;
  assign pc_target_o         = tgt_ff;
  assign push_return_o       = push_ff;
  assign asleep_o            = asleep_ff;
  assign last_event_o        = last_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_irq_wake_en;
    clk_en_i && evt.ev == RCR_EV_IRQ_WAKE && global_irq_enable_i;
  endsequence
  sequence s_vec_done;
    clk_en_i && instr_done_i && evt.ev == RCR_EV_NONE;
  endsequence

  a_por_flags: assert property (clk_en_i && evt.ev == RCR_EV_POR |=>
    status_o[4:3] == 2'b11 && power_control_reg_o == 8'h1C)
    else $error("power-on flags wrong");
  a_bor_flags: assert property (clk_en_i && evt.ev == RCR_EV_BOR |=>
    power_control_reg_o[7:6] == 2'b00 && !power_control_reg_o[0]
    && power_control_reg_o[4] == $past(power_control_reg_o[4]))
    else $error("brown-out flags wrong");
  a_wdt_reset: assert property (clk_en_i && evt.ev == RCR_EV_WDT_RST |=>
    !status_o[4] && !power_control_reg_o[4] && pc_load_o
    && pc_target_o == 13'h0000)
    else $error("watchdog reset wrong");
  a_wdt_wake: assert property (clk_en_i && evt.ev == RCR_EV_WDT_WAKE |=>
    status_o[4:3] == 2'b00 && pc_target_o == PC_W'($past(pc_i) + 1'b1))
    else $error("watchdog wake wrong");
  a_irq_wake: assert property (clk_en_i && evt.ev == RCR_EV_IRQ_WAKE |=>
    status_o[4:3] == 2'b10 && pc_load_o)
    else $error("interrupt wake wrong");
  a_irq_vector: assert property (s_irq_wake_en ##1 s_vec_done |=>
    push_return_o && pc_target_o == 13'h0004)
    else $error("interrupt vector wrong");
  a_pin_sleep: assert property (clk_en_i && evt.ev == RCR_EV_PIN_SLP |=>
    status_o[4:3] == 2'b10 && !power_control_reg_o[3])
    else $error("pin sleep reset wrong");
  a_instr_reset: assert property (clk_en_i && evt.ev == RCR_EV_INSTR
    && !sw_wr_power_control_reg_i |=> !power_control_reg_o[2]
    && power_control_reg_o[7:3] == $past(power_control_reg_o[7:3]))
    else $error("instruction reset wrong");
  a_stack_ovf: assert property (clk_en_i && evt.ev == RCR_EV_OVF |=>
    power_control_reg_o[7] && pc_target_o == 13'h0000)
    else $error("overflow reset wrong");
  a_unimpl_zero: assert property (status_o[7:5] == 3'h0
    && !power_control_reg_o[5])
    else $error("unimplemented bit set");
endmodule

// file: tb/rcr_core_model.sv
`timescale 1ns/1ns
// ------
// Far side: reset sources, sleep wake and core retire pulse
// ------
module rcr_core_model
  import rcr_pkg::*;
(
  input  wire logic              clock_i,
  input  rcr_pkg::rcr_event_type cmd_i,
  input  wire logic              done_req_i,
  input  wire logic [3:0]        done_dly_i,
  output logic                   por_o,
  output logic                   bor_o,
  output logic                   wdt_o,
  output logic                   pin_o,
  output logic                   instr_o,
  output logic                   ovf_o,
  output logic                   unf_o,
  output logic                   irq_o,
  output logic                   done_o
);
  logic [3:0] cnt_ff = 4'h0;

  initial begin
    {por_o, bor_o, wdt_o, pin_o, instr_o} = 5'h00;
    {ovf_o, unf_o, irq_o, done_o} = 4'h0;
  end

  // One pulse of one cycle for each request
  always @(posedge clock_i) begin
    por_o   <= cmd_i == RCR_EV_POR;
    bor_o   <= cmd_i == RCR_EV_BOR;
    wdt_o   <= cmd_i inside {RCR_EV_WDT_RST, RCR_EV_WDT_WAKE};
    pin_o   <= cmd_i inside {RCR_EV_PIN_RUN, RCR_EV_PIN_SLP};
    instr_o <= cmd_i == RCR_EV_INSTR;
    ovf_o   <= cmd_i == RCR_EV_OVF;
    unf_o   <= cmd_i == RCR_EV_UNF;
    irq_o   <= cmd_i == RCR_EV_IRQ_WAKE;
    // Retire pulse, prompt or slow, after the wake
    if (done_req_i) begin
      cnt_ff <= done_dly_i;
    end else if (cnt_ff != 4'h0) begin
      cnt_ff <= cnt_ff - 4'h1;
    end
    done_o <= cnt_ff == 4'h1;
  end
endmodule

// file: tb/rcr_reset_cause_recorder_tb_top.sv
`timescale 1ns/1ns
`include "rcr_defs.svh"
module rcr_reset_cause_recorder_tb_top;
  import rcr_pkg::*;
  typedef struct packed {
    logic [7:0]  st;
    logic [7:0]  pw;
    logic [12:0] tg;
    logic        pu;
    logic [3:0]  ev;
  } rcr_note_type;
  logic [3:0]    last_ev;
  logic          clock_i = 1'b0;
  logic          reset_n_i = 1'b0;
  logic          clk_en = 1'b1;
  logic          sfe = 1'b1;
  logic          global_irq_enable = 1'b0;
  logic          slp_req = 1'b0;
  logic          done_req = 1'b0;
  logic [3:0]    dly = 4'h2;
  logic [12:0]   pc = 13'h0000;
  logic          wr_st = 1'b0;
  logic          wr_pw = 1'b0;
  logic [7:0]    d_st = 8'h00;
  logic [7:0]    d_pw = 8'h00;
  rcr_event_type cmd = RCR_EV_NONE;
  logic          por, bor, wdt, pin, ins, ovf, unf, irq, done;
  logic [7:0]    status, power_control_reg;
  logic          pc_load, push, asleep;
  logic [12:0]   target;
  rcr_note_type  q[$];
  rcr_note_type  nt;
  logic [7:0]    e_st = 8'h18;
  logic [7:0]    e_pw = 8'h1C;
  logic          slp = 1'b0;
  int            seed = 41161;
  int            n_fail = 0;
  int            samples_checked = 0;
  rcr_event_type kinds [10] = '{RCR_EV_POR, RCR_EV_BOR, RCR_EV_WDT_RST,
    RCR_EV_WDT_WAKE, RCR_EV_IRQ_WAKE, RCR_EV_PIN_RUN, RCR_EV_PIN_SLP,
    RCR_EV_INSTR, RCR_EV_OVF, RCR_EV_UNF};

  initial begin
    forever #20 clock_i = ~clock_i;
  end

  rcr_core_model i_rcr_core_model (.clock_i(clock_i), .cmd_i(cmd),
    .done_req_i(done_req), .done_dly_i(dly), .por_o(por), .bor_o(bor),
    .wdt_o(wdt), .pin_o(pin), .instr_o(ins), .ovf_o(ovf), .unf_o(unf),
    .irq_o(irq), .done_o(done));

  rcr_reset_cause_recorder i_rcr_reset_cause_recorder (.clock_i(clock_i),
    .reset_n_i(reset_n_i), .clk_en_i(clk_en), .por_i(por), .bor_i(bor),
    .wdt_timeout_i(wdt), .ext_pin_i(pin), .instr_reset_i(ins),
    .stack_ovf_i(ovf), .stack_unf_i(unf), .stack_fault_reset_en_i(sfe),
    .sleep_req_i(slp_req), .irq_wake_i(irq), .global_irq_enable_i(global_irq_enable),
    .instr_done_i(done), .pc_i(pc), .sw_wr_status_i(wr_st),
    .sw_status_i(d_st), .sw_wr_power_control_reg_i(wr_pw), .sw_power_control_reg_i(d_pw),
    .status_o(status), .power_control_reg_o(power_control_reg), .pc_load_o(pc_load),
    .pc_target_o(target), .push_return_o(push), .asleep_o(asleep),
    .last_event_o(last_ev));

  // ------
  // Shared tasks
  // ------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic fire(input rcr_event_type e, input logic d,
                      input logic g, input logic [12:0] p);
    @(posedge clock_i);
    #1;
    cmd = e;
    done_req = d;
    global_irq_enable = g;
    pc = p;
    dly = 4'h1 + 4'($unsigned($random(seed)) % 7);
    @(posedge clock_i);
    #1;
    cmd = RCR_EV_NONE;
    done_req = 1'b0;
  endtask

  task automatic nap();
    @(posedge clock_i);
    #1;
    slp_req = 1'b1;
    @(posedge clock_i);
    #1;
    slp_req = 1'b0;
    slp = 1'b1;
    @(negedge clock_i);
    chk(16'(asleep), 16'h0001);
  endtask

  task automatic drain();
    repeat (40) begin
      if (q.size() != 0) @(posedge clock_i);
    end
    chk(16'(q.size()), 16'h0000);
  endtask

  task automatic ev(input rcr_event_type e, input logic g);
    rcr_note_type n;
    logic [12:0]  p;
    logic         v;
    p = 13'($random(seed));
    v = g && e == RCR_EV_IRQ_WAKE;
    if (!slp && e inside {RCR_EV_WDT_WAKE, RCR_EV_IRQ_WAKE,
                          RCR_EV_PIN_SLP}) begin
      nap();
    end
    n.tg = `RCR_RESET_VECTOR;
    n.pu = 1'b0;
    n.ev = 4'(e);
    case (e)
      RCR_EV_POR: {e_st, e_pw} = 16'h181C;
      RCR_EV_BOR: begin
        e_st[4:3] = 2'b11;
        e_pw = {3'b000, e_pw[4], 2'b11, e_pw[1], 1'b0};
      end
      RCR_EV_WDT_RST: {e_st[4], e_pw[4]} = 2'b00;
      RCR_EV_WDT_WAKE: begin
        e_st[4:3] = 2'b00;
        n.tg = p + 13'h1;
      end
      RCR_EV_IRQ_WAKE: begin
        e_st[4:3] = 2'b10;
        n.tg = p + 13'h1;
      end
      RCR_EV_PIN_RUN: e_pw[3] = 1'b0;
      RCR_EV_PIN_SLP: {e_st[4:3], e_pw[3]} = 3'b100;
      RCR_EV_INSTR: e_pw[2] = 1'b0;
      RCR_EV_OVF: e_pw[7] = 1'b1;
      RCR_EV_UNF: e_pw[6] = 1'b1;
      default: ;
    endcase
    slp = 1'b0;
    n.st = e_st;
    n.pw = e_pw;
    q.push_back(n);
    if (v) begin
      n.tg = `RCR_IRQ_VECTOR;
      n.pu = 1'b1;
      q.push_back(n);
    end
    fire(e, v, g, p);
    if (v) drain();
  endtask

  task automatic nogo(input rcr_event_type e);
    fire(e, 1'b0, global_irq_enable, pc);
    repeat (3) @(posedge clock_i);
    @(negedge clock_i);
    chk(16'(status), 16'(e_st));
    chk(16'(power_control_reg), 16'(e_pw));
  endtask

  task automatic sw(input logic [7:0] s, input logic [7:0] p);
    @(posedge clock_i);
    #1;
    {wr_st, wr_pw, d_st, d_pw} = {2'b11, s, p};
    @(posedge clock_i);
    #1;
    {wr_st, wr_pw} = 2'b00;
    e_st = s & 8'h18;
    e_pw = p & 8'hDF;
    @(negedge clock_i);
    chk(16'(status), 16'(e_st));
    chk(16'(power_control_reg), 16'(e_pw));
  endtask

  // ------
  // Result watcher
  // ------
  always @(negedge clock_i) begin
    if (pc_load === 1'b1) begin
      if (q.size() == 0) begin
        chk(16'h0001, 16'h0000);
      end else begin
        nt = q.pop_front();
        chk(16'(status), 16'(nt.st));
        chk(16'(power_control_reg), 16'(nt.pw));
        chk(16'(target), 16'(nt.tg));
        chk(16'(push), 16'(nt.pu));
        chk(16'(last_ev), 16'(nt.ev));
        chk(16'(asleep), 16'h0000);
      end
    end
  end

  initial begin
    #400000;
    n_fail++;
    complete_run();
  end

  // ------
  // Main sequence
  // ------
  initial begin
    repeat (8) @(posedge clock_i);
    #1;
    reset_n_i = 1'b1;
    @(negedge clock_i);
    chk(16'(status), 16'h0018);
    chk(16'(power_control_reg), 16'h001C);
    foreach (kinds[i]) ev(kinds[i], 1'b0);
    ev(RCR_EV_IRQ_WAKE, 1'b1);
    sfe = 1'b0;
    nogo(RCR_EV_OVF);
    nogo(RCR_EV_UNF);
    sfe = 1'b1;
    nogo(RCR_EV_IRQ_WAKE);
    clk_en = 1'b0;
    nogo(RCR_EV_WDT_RST);
    clk_en = 1'b1;
    nap();
    nogo(RCR_EV_INSTR);
    ev(RCR_EV_WDT_WAKE, 1'b0);
    repeat (80) begin
      if ($random(seed) % 4 == 0) sw(8'($random(seed)), 8'($random(seed)));
      ev(kinds[$unsigned($random(seed)) % 10], 1'($random(seed)));
    end
    drain();
    complete_run();
  end
endmodule
